// *** logic/wecu_consts.vh ***
`ifndef WECU_CONSTS_VH
`define WECU_CONSTS_VH

// clock
`define WECU_CLK_PERIOD_NS 10

// register indices, byte address is four times the index
`define WECU_IDX_MODE 8'h01
`define WECU_IDX_CONFIG 8'h02
`define WECU_IDX_SYS_EN 8'h04
`define WECU_IDX_SUP_EN 8'h05
`define WECU_IDX_TRX_EN 8'h06
`define WECU_IDX_WAKE_EN 8'h07
`define WECU_IDX_GLOBAL 8'h60
`define WECU_IDX_SYS_STAT 8'h61
`define WECU_IDX_SUP_STAT 8'h62
`define WECU_IDX_TRX_STAT 8'h63
`define WECU_IDX_WAKE_STAT 8'h64

// system group bits
`define WECU_SYS_WDF 0
`define WECU_SYS_SERIAL_PORT_FAILURE_EVENT 1
`define WECU_SYS_OTW 2
`define WECU_SYS_PO 4
// supply group bits
`define WECU_SUP_V1U 0
`define WECU_SUP_UV 1
`define WECU_SUP_OV 2
// transceiver group bits
`define WECU_TRX_CW 0
`define WECU_TRX_CF 1
`define WECU_TRX_CBS 4
`define WECU_TRX_PARTIAL_NET_FRAME_ERROR_EVENT 5
// wake pin group bits
`define WECU_WAKE_FALL 0
`define WECU_WAKE_RISE 1
// config bits
`define WECU_CFG_LOCKOUT 0

// writable masks
`define WECU_SYS_MASK 8'h17
`define WECU_SUP_MASK 8'h07
`define WECU_TRX_MASK 8'h33
`define WECU_WAKE_MASK 8'h03
`define WECU_SYS_EN_MASK 8'h06
`define WECU_TRX_EN_MASK 8'h13

// reset values
`define WECU_EN_RST 8'h00
`define WECU_SYS_STAT_RST 8'h10
`define WECU_LOCKOUT_RST 1'b0

// mode codes
`define WECU_MC_SLEEP 3'h1
`define WECU_MC_STANDBY 3'h4
`define WECU_MC_NORMAL 3'h7

`endif

// *** logic/wecu_pin_edge.v ***
`timescale 1ns/1ps
`default_nettype none

module wecu_pin_edge (
    input wire mclk,
    input wire reset,
    input wire ce,
    input wire pin,
    output wire level,
    output wire rise,
    output wire fall
);

reg meta;
reg sync;
reg last;

always @(posedge mclk or posedge reset) begin
    if (reset) begin
        meta <= 1'b0;
        sync <= 1'b0;
        last <= 1'b0;
    end else if (ce) begin
        meta <= pin;
        sync <= meta;
        last <= sync;
    end
end

assign level = sync;
assign rise = ce & sync & ~last;
assign fall = ce & ~sync & last;

endmodule

`default_nettype wire

// *** logic/wecu_delay_timer.v ***
`timescale 1ns/1ps
`default_nettype none

module wecu_delay_timer #(
    parameter COUNT = 100000,
    parameter WIDTH = 17
) (
    input wire mclk,
    input wire reset,
    input wire ce,
    input wire start,
    input wire stop,
    output wire running
);

reg [WIDTH-1:0] left;

// stop wins over start so a falling reset pin always halts the timer
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        left <= {WIDTH{1'b0}};
    end else if (ce) begin
        if (stop) begin
            left <= {WIDTH{1'b0}};
        end else if (start) begin
            left <= COUNT[WIDTH-1:0];
        end else if (left != {WIDTH{1'b0}}) begin
            left <= left - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
end

assign running = (left != {WIDTH{1'b0}});

endmodule

`default_nettype wire

// *** logic/wecu_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "wecu_consts.vh"

module wecu_top #(
    parameter EVENT_DELAY_NS = 1000000,
    parameter RESET_HOLD_CYCLES = 20,
    parameter TIMER_WIDTH = 17
) (
    input wire mclk,
    input wire reset,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire wake_pin,
    input wire can_offline,
    input wire overtemp_shutdown,
    input wire battery_off,
    input wire can_bus_wake_event,
    input wire power_on_event,
    input wire overtemp_warning_event,
    input wire serial_port_failure_event,
    input wire watchdog_failure_event,
    input wire second_supply_overvoltage_event,
    input wire offboard_supply_overvoltage_event,
    input wire second_supply_undervoltage_event,
    input wire offboard_supply_undervoltage_event,
    input wire host_supply_undervoltage_event,
    input wire partial_net_frame_error_event,
    input wire bus_silence_event,
    input wire transceiver_failure_event,
    output reg rxd_low_n,
    output reg reset_output_low_pin,
    output reg host_supply_on,
    output wire [2:0] mode_state
);

localparam EVENT_DELAY_CYCLES = EVENT_DELAY_NS / `WECU_CLK_PERIOD_NS;

localparam [2:0] M_OFF = 3'h0;
localparam [2:0] M_RESET = 3'h1;
localparam [2:0] M_STANDBY = 3'h2;
localparam [2:0] M_NORMAL = 3'h3;
localparam [2:0] M_SLEEP = 3'h4;
localparam [2:0] M_OVERTEMP = 3'h5;

function [7:0] reg_index;
    input [11:0] addr;
    begin
        reg_index = addr[9:2];
    end
endfunction

function is_low_mode;
    input [2:0] m;
    begin
        is_low_mode = (m == M_RESET) || (m == M_SLEEP) || (m == M_OVERTEMP) || (m == M_OFF);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// wake pin and apb decode

wire wake_rise;
wire wake_fall;

wecu_pin_edge u_wake (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .pin(wake_pin),
    .level(),
    .rise(wake_rise),
    .fall(wake_fall)
);

reg [7:0] sys_stat;
reg [7:0] sup_stat;
reg [7:0] trx_stat;
reg [7:0] wake_stat;
reg [7:0] sys_en;
reg [7:0] sup_en;
reg [7:0] trx_en;
reg [7:0] wake_en;
reg lockout;
reg [2:0] mode;
reg [7:0] hold_cnt;

wire [7:0] idx = reg_index(paddr);
wire mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
    ((idx == `WECU_IDX_MODE) || (idx == `WECU_IDX_CONFIG) ||
     (idx == `WECU_IDX_SYS_EN) || (idx == `WECU_IDX_SUP_EN) ||
     (idx == `WECU_IDX_TRX_EN) || (idx == `WECU_IDX_WAKE_EN) ||
     (idx == `WECU_IDX_GLOBAL) || (idx == `WECU_IDX_SYS_STAT) ||
     (idx == `WECU_IDX_SUP_STAT) || (idx == `WECU_IDX_TRX_STAT) ||
     (idx == `WECU_IDX_WAKE_STAT));
wire access = psel & penable & ce;
wire wr = access & pwrite & mapped;
wire [7:0] wbyte = pwdata[7:0];

// no wait state: read data is loaded in setup and handed over in access
assign pready = penable & ce;
assign pslverr = psel & penable & ~mapped;

////////////////////////////////////////////////////////////////////////////////
// summary and read path

wire [3:0] summary;
assign summary[0] = |sys_stat;
assign summary[1] = |sup_stat;
assign summary[2] = |trx_stat;
assign summary[3] = |wake_stat;
wire pending = |summary;

reg [7:0] rd_val;
always @* begin
    rd_val = 8'h00;
    case (idx)
        `WECU_IDX_MODE: rd_val = {5'h00, mode};
        `WECU_IDX_CONFIG: rd_val = {7'h00, lockout};
        `WECU_IDX_SYS_EN: rd_val = sys_en;
        `WECU_IDX_SUP_EN: rd_val = sup_en;
        `WECU_IDX_TRX_EN: rd_val = trx_en;
        `WECU_IDX_WAKE_EN: rd_val = wake_en;
        `WECU_IDX_GLOBAL: rd_val = {4'h0, summary};
        `WECU_IDX_SYS_STAT: rd_val = sys_stat;
        `WECU_IDX_SUP_STAT: rd_val = sup_stat;
        `WECU_IDX_TRX_STAT: rd_val = trx_stat;
        `WECU_IDX_WAKE_STAT: rd_val = {6'h00, wake_stat[1:0]};
        default: rd_val = 8'h00;
    endcase
end

// reads only copy state, so polling never touches the rxd signalling
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        prdata <= 32'h00000000;
    end else if (ce && psel && !penable) begin
        prdata <= {24'h000000, mapped ? rd_val : 8'h00};
    end
end

////////////////////////////////////////////////////////////////////////////////
// sleep command handling

wire regular_enabled = trx_en[`WECU_TRX_CW] | wake_en[`WECU_WAKE_RISE] | wake_en[`WECU_WAKE_FALL];
wire mode_wr = wr && (idx == `WECU_IDX_MODE);
wire sleep_cmd = mode_wr && (wbyte[2:0] == `WECU_MC_SLEEP);
wire lockout_hit = sleep_cmd & lockout;
wire sleep_ok = sleep_cmd & ~lockout & regular_enabled & ~pending;

////////////////////////////////////////////////////////////////////////////////
// event capture

wire [7:0] sys_set;
wire [7:0] sup_set;
wire [7:0] trx_set;
wire [7:0] wake_set;

// po, wdf and partial_net_frame_error_event bypass the enables
assign sys_set = {3'h0, power_on_event, 1'b0,
    overtemp_warning_event & sys_en[`WECU_SYS_OTW],
    (serial_port_failure_event | lockout_hit) & sys_en[`WECU_SYS_SERIAL_PORT_FAILURE_EVENT],
    watchdog_failure_event};
assign sup_set = {5'h00,
    (second_supply_overvoltage_event | offboard_supply_overvoltage_event) & sup_en[`WECU_SUP_OV],
    (second_supply_undervoltage_event | offboard_supply_undervoltage_event) & sup_en[`WECU_SUP_UV],
    host_supply_undervoltage_event & sup_en[`WECU_SUP_V1U]};
assign trx_set = {2'h0, partial_net_frame_error_event,
    bus_silence_event & trx_en[`WECU_TRX_CBS], 2'h0,
    transceiver_failure_event & trx_en[`WECU_TRX_CF],
    can_bus_wake_event & trx_en[`WECU_TRX_CW]};
assign wake_set = {6'h00, wake_rise & wake_en[`WECU_WAKE_RISE],
    wake_fall & wake_en[`WECU_WAKE_FALL]};

wire [7:0] sys_clr = (wr && idx == `WECU_IDX_SYS_STAT) ? (wbyte & `WECU_SYS_MASK) : 8'h00;
wire [7:0] sup_clr = (wr && idx == `WECU_IDX_SUP_STAT) ? (wbyte & `WECU_SUP_MASK) : 8'h00;
wire [7:0] trx_clr = (wr && idx == `WECU_IDX_TRX_STAT) ? (wbyte & `WECU_TRX_MASK) : 8'h00;
wire [7:0] wake_clr = (wr && idx == `WECU_IDX_WAKE_STAT) ? (wbyte & `WECU_WAKE_MASK) : 8'h00;

// a clear counts only if the bit was actually set
wire any_cleared = |(sys_clr & sys_stat) | |(sup_clr & sup_stat) |
    |(trx_clr & trx_stat) | |(wake_clr & wake_stat);

// set wins over a clear in the same cycle so no event is lost
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        sys_stat <= `WECU_SYS_STAT_RST;
        sup_stat <= 8'h00;
        trx_stat <= 8'h00;
        wake_stat <= 8'h00;
    end else if (ce) begin
        sys_stat <= (sys_stat & ~sys_clr) | sys_set;
        sup_stat <= (sup_stat & ~sup_clr) | sup_set;
        trx_stat <= (trx_stat & ~trx_clr) | trx_set;
        wake_stat <= (wake_stat & ~wake_clr) | wake_set;
    end
end

////////////////////////////////////////////////////////////////////////////////
// enables and configuration

always @(posedge mclk or posedge reset) begin
    if (reset) begin
        sys_en <= `WECU_EN_RST;
        sup_en <= `WECU_EN_RST;
        trx_en <= `WECU_EN_RST;
        wake_en <= `WECU_EN_RST;
        lockout <= `WECU_LOCKOUT_RST;
    end else if (ce && wr) begin
        if (idx == `WECU_IDX_SYS_EN) begin
            sys_en <= wbyte & `WECU_SYS_EN_MASK;
        end
        if (idx == `WECU_IDX_SUP_EN) begin
            sup_en <= wbyte & `WECU_SUP_MASK;
        end
        if (idx == `WECU_IDX_TRX_EN) begin
            trx_en <= wbyte & `WECU_TRX_EN_MASK;
        end
        if (idx == `WECU_IDX_WAKE_EN) begin
            wake_en <= wbyte & `WECU_WAKE_MASK;
        end
        // lockout can be set but never cleared by software
        if (idx == `WECU_IDX_CONFIG && wbyte[`WECU_CFG_LOCKOUT]) begin
            lockout <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode machine

reg [2:0] next_mode;
always @* begin
    next_mode = mode;
    case (mode)
        M_OFF: begin
            if (!battery_off) begin
                next_mode = M_RESET;
            end
        end
        M_RESET: begin
            if (hold_cnt == RESET_HOLD_CYCLES[7:0]) begin
                next_mode = M_STANDBY;
            end
        end
        M_STANDBY, M_NORMAL: begin
            if (sleep_cmd && !lockout) begin
                next_mode = sleep_ok ? M_SLEEP : M_RESET;
            end else if (mode_wr && wbyte[2:0] == `WECU_MC_NORMAL) begin
                next_mode = M_NORMAL;
            end else if (mode_wr && wbyte[2:0] == `WECU_MC_STANDBY) begin
                next_mode = M_STANDBY;
            end
        end
        M_SLEEP: begin
            if (pending) begin
                next_mode = M_RESET;
            end
        end
        M_OVERTEMP: begin
            if (!overtemp_shutdown) begin
                next_mode = M_RESET;
            end
        end
        default: next_mode = M_RESET;
    endcase
    if (overtemp_shutdown && mode != M_OFF) begin
        next_mode = M_OVERTEMP;
    end
    if (battery_off) begin
        next_mode = M_OFF;
    end
end

always @(posedge mclk or posedge reset) begin
    if (reset) begin
        mode <= M_RESET;
        hold_cnt <= 8'h00;
    end else if (ce) begin
        mode <= next_mode;
        if (next_mode != M_RESET || mode != M_RESET) begin
            hold_cnt <= 8'h00;
        end else begin
            hold_cnt <= hold_cnt + 8'h01;
        end
    end
end

assign mode_state = mode;

////////////////////////////////////////////////////////////////////////////////
// reset pin, delay timer and rxd signalling

reg rst_pin_prev;
wire rst_pin_fall = rst_pin_prev & ~reset_output_low_pin;
wire timer_running;

wecu_delay_timer #(
    .COUNT(EVENT_DELAY_CYCLES),
    .WIDTH(TIMER_WIDTH)
) u_timer (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .start(any_cleared),
    .stop(rst_pin_fall),
    .running(timer_running)
);

wire alert_mode = (can_offline && (mode == M_STANDBY || mode == M_NORMAL)) || (mode == M_SLEEP);
// while the timer runs rxd stays high; at expiry it follows pending again
wire next_rxd_low_n = ~(pending & alert_mode & ~timer_running & ~any_cleared);

always @(posedge mclk or posedge reset) begin
    if (reset) begin
        rxd_low_n <= 1'b1;
        reset_output_low_pin <= 1'b0;
        rst_pin_prev <= 1'b0;
        host_supply_on <= 1'b0;
    end else if (ce) begin
        rxd_low_n <= next_rxd_low_n;
        reset_output_low_pin <= ~is_low_mode(next_mode);
        rst_pin_prev <= reset_output_low_pin;
        host_supply_on <= (next_mode != M_SLEEP) && (next_mode != M_OFF);
    end
end

endmodule

`default_nettype wire

// *** testbench/wecu_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "wecu_consts.vh"
module wecu_monitor #(
    parameter int EVENT_DELAY_NS = 1000000
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic can_offline,
    input wire logic rxd_low_n,
    input wire logic reset_output_low_pin,
    input wire logic host_supply_on,
    input wire logic [2:0] mode_state
);
    localparam int DLY = EVENT_DELAY_NS / 10;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // cycles since rxd was released; a reset pin drop or an online transceiver kills the hold-off
    logic [31:0] hi_cnt;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            hi_cnt <= 32'hffffffff;
        else if (!reset_output_low_pin || !can_offline)
            hi_cnt <= 32'hffffffff;
        else if (!rxd_low_n)
            hi_cnt <= 32'h00000000;
        else if (hi_cnt != 32'hffffffff)
            hi_cnt <= hi_cnt + 32'h00000001;
    end
    ////////////////////////////////////////
    a_pin_low_modes: assert property (mode_state inside {3'h0, 3'h1, 3'h4, 3'h5} |-> !reset_output_low_pin)
        else $error("reset pin high in a reset mode");
    a_sleep_supply: assert property (mode_state == 3'h4 |-> !host_supply_on)
        else $error("host supply on in sleep");
    a_sleep_exit: assert property (mode_state == 3'h4 ##1 mode_state != 3'h4 |-> mode_state inside {3'h0, 3'h1, 3'h5})
        else $error("sleep left other than through reset");
    a_sleep_entry: assert property ($rose(mode_state == 3'h4) |-> $past(psel) && $past(penable) &&
        $past(pwrite) && $past(paddr) == {`WECU_IDX_MODE, 2'b00} &&
        ($past(pwdata) & 32'h00000007) == {29'h0, `WECU_MC_SLEEP})
        else $error("sleep entered without a command");
    a_global_upper: assert property (psel && penable && !pwrite && paddr == {`WECU_IDX_GLOBAL, 2'b00}
        |-> prdata[31:4] == 28'h0)
        else $error("summary upper bits not zero");
    a_rxd_cause: assert property ($fell(rxd_low_n) |-> $past(mode_state) == 3'h4 ||
        ($past(can_offline) && $past(mode_state) inside {3'h2, 3'h3}))
        else $error("rxd pulled low outside an alert mode");
    a_delay_hold: assert property ($fell(rxd_low_n) |-> hi_cnt >= DLY - 2)
        else $error("rxd pulled low before the delay ran out");
    a_read_no_wait: assert property (psel && penable && ce |-> pready)
        else $error("access not answered at once");
    c_sleep: cover property ($rose(mode_state == 3'h4));
    c_alert: cover property ($fell(rxd_low_n));
    c_release: cover property ($rose(rxd_low_n));
endmodule
bind wecu_top wecu_monitor #(.EVENT_DELAY_NS(EVENT_DELAY_NS)) wecu_monitor_i (.mclk, .reset, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .can_offline, .rxd_low_n, .reset_output_low_pin,
    .host_supply_on, .mode_state);
`default_nettype wire

// *** testbench/wecu_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module wecu_host_model (
    input wire logic mclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [11:0] paddr = 12'h000,
    output logic [31:0] pwdata = 32'h0,
    output logic hung = 1'b0
);
    // request fields stay put until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!pready && n < 50);
        if (!pready)
            hung <= 1'b1;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // write back only what was read, so a late event is kept
    task automatic clear_seen(input logic [7:0] idx);
        logic [31:0] seen;
        logic e;
        xfer(1'b0, idx, 8'h00, seen, e);
        xfer(1'b1, idx, seen[7:0], seen, e);
    endtask
endmodule
`default_nettype wire

// *** testbench/wecu_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "wecu_consts.vh"
module wecu_top_tb;
    localparam int DLY = 200;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic wake_pin = 1'b0;
    logic overtemp_shutdown = 1'b0;
    logic can_offline = 1'b1;
    logic battery_off = 1'b0;
    logic [12:0] ev = 13'h0;
    logic psel, penable, pwrite, pready, pslverr, hung, rxd_low_n, reset_output_low_pin, host_supply_on, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] mode_state;
    int num_errors = 0;
    int n_compared = 0;
    int ticks = 0;
    wecu_top #(.EVENT_DELAY_NS(DLY * 10)) wecu_top_i (.mclk, .reset, .ce(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .wake_pin, .can_offline, .overtemp_shutdown,
        .battery_off, .can_bus_wake_event(ev[0]), .power_on_event(ev[1]), .overtemp_warning_event(ev[2]),
        .serial_port_failure_event(ev[3]), .watchdog_failure_event(ev[4]),
        .second_supply_overvoltage_event(ev[5]), .offboard_supply_overvoltage_event(ev[6]),
        .second_supply_undervoltage_event(ev[7]), .offboard_supply_undervoltage_event(ev[8]),
        .host_supply_undervoltage_event(ev[9]), .partial_net_frame_error_event(ev[10]),
        .bus_silence_event(ev[11]), .transceiver_failure_event(ev[12]), .rxd_low_n, .reset_output_low_pin,
        .host_supply_on, .mode_state);
    wecu_host_model wecu_host_model_i (.mclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
        .pwdata, .hung);
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) ticks <= ticks + 1;
    always @(posedge hung) begin
        num_errors++;
        stop_test();
    end
    ////////////////////////////////////////
    task automatic stop_test();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wecu_host_model_i.xfer(1'b1, idx, d, rd, err);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        wecu_host_model_i.xfer(1'b0, idx, 8'h00, rd, err);
        chk(rd, exp);
    endtask
    task automatic pulse(input int k);
        @(posedge mclk) ev <= 13'h1 << k;
        @(posedge mclk) ev <= 13'h0;
    endtask
    task automatic pin(input logic v);
        @(posedge mclk) wake_pin <= v;
        cyc(6);
    endtask
    task automatic wait_mode(input logic [2:0] m);
        int n;
        for (n = 0; n < 100 && mode_state !== m; n++) @(posedge mclk);
        #1;
        if (mode_state !== m) begin
            num_errors++;
            stop_test();
        end
    endtask
    task automatic clr_all();
        for (int i = 0; i < 4; i++) wecu_host_model_i.clear_seen(8'(`WECU_IDX_SYS_STAT + i));
    endtask
    task automatic sleep_cmd(input logic [2:0] m);
        wr(`WECU_IDX_MODE, {5'h0, `WECU_MC_SLEEP});
        cyc(2);
        chk(mode_state, m);
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        wait_mode(3'h2);
        rdc(`WECU_IDX_SYS_STAT, 32'h10);
        rdc(`WECU_IDX_TRX_EN, 32'h0);
        rdc(`WECU_IDX_GLOBAL, 32'h1);
        chk(rxd_low_n, 0);
        wr(`WECU_IDX_SYS_STAT, 8'h00);
        rdc(`WECU_IDX_SYS_STAT, 32'h10);
        wr(`WECU_IDX_SYS_STAT, 8'h10);
        cyc(2);
        chk(rxd_low_n, 1);
        rdc(`WECU_IDX_GLOBAL, 32'h0);
    endtask
    task automatic t_delay();
        int c0;
        cyc(DLY);
        pulse(2);
        rdc(`WECU_IDX_SYS_STAT, 32'h0);
        wr(`WECU_IDX_SYS_EN, 8'h04);
        pulse(2);
        pulse(4);
        rdc(`WECU_IDX_SYS_STAT, 32'h05);
        chk(rxd_low_n, 0);
        wr(`WECU_IDX_SYS_STAT, 8'h05);
        c0 = ticks;
        pulse(4);
        rdc(`WECU_IDX_SYS_STAT, 32'h01);
        chk(rxd_low_n, 1);
        for (int n = 0; n < 3 * DLY && rxd_low_n; n++) cyc(1);
        chk((ticks - c0) inside {[DLY : DLY + 4]}, 1);
        wr(`WECU_IDX_SYS_STAT, 8'h01);
        pulse(4);
        wecu_host_model_i.clear_seen(`WECU_IDX_SYS_STAT);
        cyc(DLY + 10);
        chk(rxd_low_n, 1);
    endtask
    task automatic t_groups();
        wr(`WECU_IDX_SUP_EN, 8'h01);
        pulse(9);
        rdc(`WECU_IDX_GLOBAL, 32'h2);
        @(posedge mclk) can_offline <= 1'b0;
        cyc(2);
        chk(rxd_low_n, 1);
        @(posedge mclk) can_offline <= 1'b1;
        cyc(2);
        chk(rxd_low_n, 0);
        pulse(10);
        rdc(`WECU_IDX_TRX_STAT, 32'h20);
        wr(`WECU_IDX_WAKE_EN, 8'h02);
        pin(1'b1);
        pin(1'b0);
        rdc(`WECU_IDX_WAKE_STAT, 32'h2);
        rdc(`WECU_IDX_GLOBAL, 32'he);
        clr_all();
        rdc(`WECU_IDX_GLOBAL, 32'h0);
    endtask
    task automatic t_sleep();
        wr(`WECU_IDX_WAKE_EN, 8'h00);
        sleep_cmd(3'h1);
        wait_mode(3'h2);
        wr(`WECU_IDX_WAKE_EN, 8'h01);
        clr_all();
        pulse(4);
        sleep_cmd(3'h1);
        wait_mode(3'h2);
        cyc(4);
        chk(rxd_low_n, 0);
        clr_all();
        sleep_cmd(3'h4);
        chk(reset_output_low_pin, 0);
        chk(host_supply_on, 0);
        pin(1'b1);
        chk(mode_state, 3'h4);
        pin(1'b0);
        chk(mode_state, 3'h1);
        wait_mode(3'h2);
        chk(host_supply_on, 1);
        rdc(`WECU_IDX_WAKE_STAT, 32'h1);
    endtask
    task automatic t_lockout();
        clr_all();
        wr(`WECU_IDX_SYS_EN, 8'h02);
        wr(`WECU_IDX_CONFIG, 8'h01);
        sleep_cmd(3'h2);
        rdc(`WECU_IDX_SYS_STAT, 32'h02);
        wecu_host_model_i.xfer(1'b0, 8'h3f, 8'h00, rd, err);
        chk(err, 1);
        chk(rd, 0);
        @(posedge mclk) overtemp_shutdown <= 1'b1;
        cyc(3);
        chk(reset_output_low_pin, 0);
        @(posedge mclk) battery_off <= 1'b1;
        cyc(3);
        chk(mode_state, 3'h0);
        chk(reset_output_low_pin, 0);
        chk(host_supply_on, 0);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_delay();
        t_groups();
        t_sleep();
        t_lockout();
        stop_test();
    end
endmodule
`default_nettype wire
